//--- rtl/sfcd_core_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfcd_core_sync (
  input wire logic core_clk,
  input wire logic rst,
  sfcd_event_if.dst ev,
  output logic pulse,
  output logic [7:0] opcode,
  output logic [7:0] data,
  output logic has_data
);
  logic [1:0] sync_q;
  logic last_q;
  // ------------------------------------------------------------
  // toggle crossing; payload is held stable by the link side
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_q <= 2'b00;
      last_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], ev.toggle};
      last_q <= sync_q[1];
      // pulse lags one cycle so that the payload below is already captured
      pulse <= sync_q[1] ^ last_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      opcode <= 8'h00;
      data <= 8'h00;
      has_data <= 1'b0;
    end else if (sync_q[1] ^ last_q) begin
      opcode <= ev.opcode;
      data <= ev.data;
      has_data <= ev.has_data;
    end
  end
endmodule
`default_nettype wire

//--- rtl/sfcd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcd_params.svh"
// How it works
// - opcode accepted only in supporting protocols
// - id opcodes split by extended versus multi-lane
// - read opcodes decoded per protocol, streaming
// - dual mode aliases three fast read codes
// - quad mode aliases three fast read codes
// - status, flag, lock opcodes in all protocols
// - configuration register opcodes in all protocols
// - program opcodes take one to 256 bytes, OTP program up to 64
// - write enable required before modifying commands
// - register and control commands take no address, except lock register read and write
// - address commands take three bytes; only fast reads add dummy
// - fast reads take configurable dummy cycles
// - lane use follows active protocol
// - chip select high ends data output
// - status readable at any time
// - flag status readable at any time
// - nonvolatile config shifts low byte first
// - protocol follows enhanced volatile bits 7,6
// - flag errors sticky until clear command
// - volatile config reads repeat one byte
module sfcd_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic chip_select_n,
  input wire logic serial_lane_zero,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  input wire logic [7:0] status_in,
  input wire logic [15:0] nvc_in,
  input wire logic [7:0] vc_in,
  input wire logic [7:0] lock_in,
  input wire logic busy,
  input wire logic [7:0] flag_err_set,
  input wire logic [3:0] dummy_cfg,
  output logic [7:0] cmd_opcode,
  output logic cmd_valid,
  output logic cmd_wel_ok,
  output logic [7:0] evc_q,
  output logic wel_q,
  output logic [7:0] flag_q,
  output sfcd_pkg::sfcd_proto_e proto
);
  import sfcd_pkg::*;
  typedef enum logic [2:0] {
    SFCD_ST_OPC = 3'h0,
    SFCD_ST_ADDR = 3'h1,
    SFCD_ST_DUMMY = 3'h3,
    SFCD_ST_DATA = 3'h2,
    SFCD_ST_IGNORE = 3'h6
  } sfcd_state_e;

  sfcd_event_if ev_if ();
  sfcd_dec_s dec;
  sfcd_dec_s cur_q;
  sfcd_state_e st_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [1:0] abyte_q;
  logic [3:0] dcnt_q;
  logic [8:0] dbyte_q;
  logic [7:0] wdata_q;
  logic wdata_v_q;
  logic [7:0] out_q;
  logic out_en_q;
  logic tog_q;
  logic [1:0] proto_sync_q;
  logic [1:0] proto_l;
  logic [7:0] ev_opc_q;
  logic [7:0] ev_dat_q;
  logic ev_has_q;
  logic [3:0] dummy_cycles;
  logic [3:0] step;
  logic [7:0] sh_d;
  logic byte_done;
  logic ev_pulse;
  logic [7:0] ev_opcode;
  logic [7:0] ev_data;
  logic ev_has_data;
  logic [7:0] reg_byte;
  logic [7:0] flag_view;
  sfcd_proto_e proto_link;

  // ------------------------------------------------------------
  // protocol select and crossings into the link domain
  // ------------------------------------------------------------
  always_comb begin
    if (!evc_q[`SFCD_EVC_QUAD_BIT] && !evc_q[`SFCD_EVC_DUAL_BIT]) begin
      proto = SFCD_PROTO_QUAD;
    end else if (!evc_q[`SFCD_EVC_DUAL_BIT]) begin
      proto = SFCD_PROTO_DUAL;
    end else begin
      proto = SFCD_PROTO_EXT;
    end
  end
  // protocol is quasi-static between frames and the link clock may be stopped,
  // so it is captured as the frame opens rather than through link clock flops
  always_ff @(negedge chip_select_n) begin
    proto_sync_q <= proto;
  end
  assign proto_l = proto_sync_q;
  assign proto_link = sfcd_proto_e'(proto_l);

  sfcd_opcode_table u_table (
    .opcode(sh_d),
    .proto(proto_link),
    .dummy_cfg(dummy_cfg),
    .dec(dec),
    .dummy_cycles(dummy_cycles)
  );

  // ------------------------------------------------------------
  // link-side shifter: lanes per step follow protocol
  // ------------------------------------------------------------
  always_comb begin
    case (proto_link)
      SFCD_PROTO_QUAD: begin
        step = 4'd4;
        sh_d = {sh_q[3:0], lane_in};
      end
      SFCD_PROTO_DUAL: begin
        step = 4'd2;
        sh_d = {sh_q[5:0], lane_in[1:0]};
      end
      default: begin
        step = 4'd1;
        sh_d = {sh_q[6:0], serial_lane_zero};
      end
    endcase
  end
  assign byte_done = (bit_q + step) == 4'd8;

  // link clock may stop outside frames: chip select resets all frame state
  always_ff @(posedge link_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      st_q <= SFCD_ST_OPC;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      cur_q <= '0;
      abyte_q <= 2'h0;
      dcnt_q <= 4'h0;
      dbyte_q <= 9'h0;
      wdata_q <= 8'h00;
      wdata_v_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bit_q <= byte_done ? 4'h0 : bit_q + step;
      case (st_q)
        SFCD_ST_OPC: begin
          if (byte_done) begin
            cur_q <= dec;
            if (!dec.valid) begin
              st_q <= SFCD_ST_IGNORE;
            end else if (dec.addr_bytes != 2'h0) begin
              st_q <= SFCD_ST_ADDR;
              abyte_q <= dec.addr_bytes;
            end else begin
              st_q <= SFCD_ST_DATA;
            end
          end
        end
        SFCD_ST_ADDR: begin
          if (byte_done) begin
            abyte_q <= abyte_q - 2'h1;
            if (abyte_q == 2'h1) begin
              st_q <= cur_q.dummy ? SFCD_ST_DUMMY : SFCD_ST_DATA;
              dcnt_q <= dummy_cycles;
              bit_q <= 4'h0;
            end
          end
        end
        SFCD_ST_DUMMY: begin
          bit_q <= 4'h0;
          dcnt_q <= dcnt_q - 4'h1;
          if (dcnt_q == 4'h1) begin
            st_q <= SFCD_ST_DATA;
          end
        end
        SFCD_ST_DATA: begin
          if (byte_done) begin
            dbyte_q <= dbyte_q + 9'h1;
            if (!wdata_v_q) begin
              wdata_q <= sh_d;
              wdata_v_q <= 1'b1;
            end
          end
        end
        SFCD_ST_IGNORE: st_q <= SFCD_ST_IGNORE;
        default: st_q <= SFCD_ST_IGNORE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register read data, shifted out on falling edges
  // ------------------------------------------------------------
  assign flag_view = {!busy, flag_q[6:0]};
  always_comb begin
    case (cur_q.cmd)
      SFCD_CMD_RD_STAT: reg_byte = {status_in[7:2], wel_q, busy};
      SFCD_CMD_RD_FLAG: reg_byte = flag_view;
      SFCD_CMD_RD_LOCK: reg_byte = lock_in;
      SFCD_CMD_RD_VC: reg_byte = vc_in;
      SFCD_CMD_RD_EVC: reg_byte = evc_q;
      SFCD_CMD_RD_NVC: begin
        if (dbyte_q == 9'h0) begin
          reg_byte = nvc_in[7:0];
        end else if (dbyte_q == 9'h1) begin
          reg_byte = nvc_in[15:8];
        end else begin
          reg_byte = 8'h00;
        end
      end
      SFCD_CMD_ID: begin
        if (dbyte_q == 9'h0) begin
          reg_byte = 8'(`SFCD_ID_WORD >> 8); // arbitrary id value
        end else if (dbyte_q == 9'h1) begin
          reg_byte = 8'(`SFCD_ID_WORD);
        end else begin
          reg_byte = 8'h00;
        end
      end
      default: reg_byte = 8'h00;
    endcase
  end

  always_ff @(negedge link_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_q <= 8'h00;
      out_en_q <= 1'b0;
    end else begin
      out_en_q <= (st_q == SFCD_ST_DATA) && (cur_q.cmd != SFCD_CMD_NONE) &&
                  (cur_q.cmd inside {SFCD_CMD_ID, SFCD_CMD_RD_STAT, SFCD_CMD_RD_FLAG,
                   SFCD_CMD_RD_LOCK, SFCD_CMD_RD_NVC, SFCD_CMD_RD_VC, SFCD_CMD_RD_EVC});
      out_q <= (bit_q == 4'h0) ? reg_byte : (out_q << step);
    end
  end

  always_comb begin
    lane_out = 4'h0;
    lane_oe = 4'h0;
    if (out_en_q) begin
      case (proto_link)
        SFCD_PROTO_QUAD: begin
          lane_out = out_q[7:4];
          lane_oe = 4'hf;
        end
        SFCD_PROTO_DUAL: begin
          lane_out = {2'b00, out_q[7:6]};
          lane_oe = 4'h3;
        end
        default: begin
          lane_out = {2'b00, out_q[7], 1'b0}; // serial_lane_one carries data
          lane_oe = 4'h2;
        end
      endcase
    end
  end

  // frame end raises an event toward the core domain if the opcode was valid; frame state is cleared on
  // this same edge, so the payload is copied here and stands until the next valid frame
  always_ff @(posedge chip_select_n or posedge rst) begin
    if (rst) begin
      tog_q <= 1'b0;
      ev_opc_q <= 8'h00;
      ev_dat_q <= 8'h00;
      ev_has_q <= 1'b0;
    end else if (cur_q.valid) begin
      tog_q <= !tog_q;
      ev_opc_q <= cur_q.opcode;
      ev_dat_q <= wdata_q;
      ev_has_q <= wdata_v_q;
    end
  end
  assign ev_if.toggle = tog_q;
  assign ev_if.opcode = ev_opc_q;
  assign ev_if.data = ev_dat_q;
  assign ev_if.has_data = ev_has_q;

  sfcd_core_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ev(ev_if.dst),
    .pulse(ev_pulse),
    .opcode(ev_opcode),
    .data(ev_data),
    .has_data(ev_has_data)
  );

  // ------------------------------------------------------------
  // core-domain effects of completed commands
  // ------------------------------------------------------------
  assign cmd_valid = ev_pulse;
  assign cmd_opcode = ev_opcode;
  assign cmd_wel_ok = ev_pulse && wel_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (ev_pulse && ev_opcode == `SFCD_OP_WREN) begin
      wel_q <= 1'b1;
    end else if (ev_pulse && ev_opcode != `SFCD_OP_WREN && ev_opcode != `SFCD_OP_RDSTAT &&
                 ev_opcode != `SFCD_OP_RDFLAG) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      evc_q <= `SFCD_EVC_RESET;
    end else if (ev_pulse && wel_q && ev_opcode == `SFCD_OP_WREVC && ev_has_data) begin
      evc_q <= ev_data;
    end
  end

  // new errors win over a clear arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= 8'h80;
    end else begin
      flag_q[`SFCD_FLAG_READY_BIT] <= !busy;
      flag_q[6:0] <= 7'(((ev_pulse && ev_opcode == `SFCD_OP_CLFLAG) ?
                         (flag_q & ~`SFCD_FLAG_ERR_MASK) : flag_q) |
                        (flag_err_set & `SFCD_FLAG_ERR_MASK));
    end
  end
endmodule
`default_nettype wire

//--- rtl/sfcd_event_if.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// frame events from link domain to core domain
// ------------------------------------------------------------
interface sfcd_event_if;
  import sfcd_pkg::*;
  logic toggle;
  logic [7:0] opcode;
  logic [7:0] data;
  logic has_data;
  modport src (output toggle, output opcode, output data, output has_data);
  modport dst (input toggle, input opcode, input data, input has_data);
endinterface
`default_nettype wire

//--- rtl/sfcd_opcode_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcd_params.svh"
module sfcd_opcode_table (
  input wire logic [7:0] opcode,
  input wire sfcd_pkg::sfcd_proto_e proto,
  input wire logic [3:0] dummy_cfg,
  output sfcd_pkg::sfcd_dec_s dec,
  output logic [3:0] dummy_cycles
);
  import sfcd_pkg::*;
  logic ext;
  logic dual;
  logic quad;
  assign ext = (proto == SFCD_PROTO_EXT);
  assign dual = (proto == SFCD_PROTO_DUAL);
  assign quad = (proto == SFCD_PROTO_QUAD);
  // zero config means default dummy count for the protocol
  assign dummy_cycles = (dummy_cfg != 4'h0) ? dummy_cfg :
                        (quad ? `SFCD_DUMMY_QUAD : `SFCD_DUMMY_EXT);

  always_comb begin
    dec = '0;
    dec.opcode = opcode;
    case (opcode)
      `SFCD_OP_RDID_A, `SFCD_OP_RDID_B: begin
        dec.valid = ext;
        dec.cmd = SFCD_CMD_ID;
        dec.max_bytes = `SFCD_ID_MAX;
      end
      `SFCD_OP_MIORDID: begin
        dec.valid = !ext;
        dec.cmd = SFCD_CMD_ID;
        dec.max_bytes = `SFCD_MIOID_MAX;
      end
      `SFCD_OP_READ: begin
        dec.valid = ext;
        dec.cmd = SFCD_CMD_RD_ARRAY;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
      end
      // fast read codes alias to the io reads in dual and quad
      `SFCD_OP_FREAD, `SFCD_OP_DISC, `SFCD_OP_RDOTP: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_RD_ARRAY;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
        dec.dummy = 1'b1;
        dec.max_bytes = (opcode == `SFCD_OP_RDOTP) ? `SFCD_OTP_MAX : 9'h0;
      end
      `SFCD_OP_DOFR, `SFCD_OP_DIOFR, `SFCD_OP_QOFR, `SFCD_OP_QIOFR: begin
        dec.valid = ((opcode == `SFCD_OP_DOFR || opcode == `SFCD_OP_DIOFR) && !quad) ||
                    ((opcode == `SFCD_OP_QOFR || opcode == `SFCD_OP_QIOFR) && !dual);
        dec.cmd = SFCD_CMD_RD_ARRAY;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
        dec.dummy = 1'b1;
      end
      `SFCD_OP_RDSTAT: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_RD_STAT; end
      `SFCD_OP_RDFLAG: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_RD_FLAG; end
      `SFCD_OP_CLFLAG: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_CLFLAG; end
      `SFCD_OP_RDLOCK: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_RD_LOCK;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
      end
      `SFCD_OP_RDNVC: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_RD_NVC;
        dec.max_bytes = `SFCD_NVC_BYTES;
      end
      `SFCD_OP_RDVC: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_RD_VC; end
      `SFCD_OP_RDEVC: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_RD_EVC; end
      `SFCD_OP_WRSTAT, `SFCD_OP_WRNVC, `SFCD_OP_WRVC, `SFCD_OP_WREVC: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_WR_REG;
        dec.needs_wel = 1'b1;
      end
      `SFCD_OP_WRLOCK: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_WR_REG;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
        dec.needs_wel = 1'b1;
      end
      `SFCD_OP_PP, `SFCD_OP_DIFP, `SFCD_OP_DIEFP, `SFCD_OP_QIFP, `SFCD_OP_QIEFP,
      `SFCD_OP_PGOTP: begin
        dec.valid = (opcode == `SFCD_OP_PP) || (opcode == `SFCD_OP_PGOTP) ||
                    ((opcode == `SFCD_OP_DIFP || opcode == `SFCD_OP_DIEFP) && !quad) ||
                    ((opcode == `SFCD_OP_QIFP || opcode == `SFCD_OP_QIEFP) && !dual);
        dec.cmd = SFCD_CMD_PROG;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
        dec.max_bytes = (opcode == `SFCD_OP_PGOTP) ? `SFCD_OTP_MAX : `SFCD_PROG_MAX;
        dec.needs_wel = 1'b1;
      end
      `SFCD_OP_SSE, `SFCD_OP_SE: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_ERASE;
        dec.addr_bytes = `SFCD_ADDR_BYTES;
        dec.needs_wel = 1'b1;
      end
      `SFCD_OP_BE: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_ERASE;
        dec.needs_wel = 1'b1;
      end
      `SFCD_OP_WREN: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_WREN; end
      `SFCD_OP_WRDI: begin dec.valid = 1'b1; dec.cmd = SFCD_CMD_WRDI; end
      `SFCD_OP_SUSPEND, `SFCD_OP_RESUME: begin
        dec.valid = 1'b1;
        dec.cmd = SFCD_CMD_SUSP;
        dec.needs_wel = 1'b1;
      end
      default: dec.valid = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

//--- rtl/sfcd_params.svh
`ifndef SFCD_PARAMS_SVH
`define SFCD_PARAMS_SVH
// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SFCD_OP_RDID_A 8'h9e
`define SFCD_OP_RDID_B 8'h9f
`define SFCD_OP_MIORDID 8'haf
`define SFCD_OP_DISC 8'h5a
`define SFCD_OP_READ 8'h03
`define SFCD_OP_FREAD 8'h0b
`define SFCD_OP_DOFR 8'h3b
`define SFCD_OP_DIOFR 8'hbb
`define SFCD_OP_QOFR 8'h6b
`define SFCD_OP_QIOFR 8'heb
`define SFCD_OP_WREN 8'h06
`define SFCD_OP_WRDI 8'h04
`define SFCD_OP_RDSTAT 8'h05
`define SFCD_OP_WRSTAT 8'h01
`define SFCD_OP_RDLOCK 8'he8
`define SFCD_OP_WRLOCK 8'he5
`define SFCD_OP_RDFLAG 8'h70
`define SFCD_OP_CLFLAG 8'h50
`define SFCD_OP_RDNVC 8'hb5
`define SFCD_OP_WRNVC 8'hb1
`define SFCD_OP_RDVC 8'h85
`define SFCD_OP_WRVC 8'h81
`define SFCD_OP_RDEVC 8'h65
`define SFCD_OP_WREVC 8'h61
`define SFCD_OP_PP 8'h02
`define SFCD_OP_DIFP 8'ha2
`define SFCD_OP_DIEFP 8'hd2
`define SFCD_OP_QIFP 8'h32
`define SFCD_OP_QIEFP 8'h12
`define SFCD_OP_SSE 8'h20
`define SFCD_OP_SE 8'hd8
`define SFCD_OP_BE 8'hc7
`define SFCD_OP_RESUME 8'h7a
`define SFCD_OP_SUSPEND 8'h75
`define SFCD_OP_RDOTP 8'h4b
`define SFCD_OP_PGOTP 8'h42
// ------------------------------------------------------------
// counts and fields
// ------------------------------------------------------------
`define SFCD_ADDR_BYTES 2'd3
`define SFCD_DUMMY_EXT 4'd8
`define SFCD_DUMMY_QUAD 4'd10
`define SFCD_ID_MAX 9'd20
`define SFCD_MIOID_MAX 9'd3
`define SFCD_PROG_MAX 9'd256
`define SFCD_OTP_MAX 9'd64
`define SFCD_NVC_BYTES 9'd2
`define SFCD_EVC_QUAD_BIT 7
`define SFCD_EVC_DUAL_BIT 6
`define SFCD_EVC_RESET 8'hdf
`define SFCD_FLAG_ERR_MASK 8'h3a
`define SFCD_FLAG_READY_BIT 7
`define SFCD_STAT_WIP_BIT 0
`define SFCD_STAT_WEL_BIT 1
`define SFCD_ID_WORD 16'h1234
`endif

//--- rtl/sfcd_pkg.sv
package sfcd_pkg;
  typedef enum logic [1:0] {
    SFCD_PROTO_EXT = 2'h0,
    SFCD_PROTO_DUAL = 2'h1,
    SFCD_PROTO_QUAD = 2'h3
  } sfcd_proto_e;

  typedef enum logic [3:0] {
    SFCD_CMD_NONE = 4'h0,
    SFCD_CMD_ID = 4'h1,
    SFCD_CMD_RD_ARRAY = 4'h2,
    SFCD_CMD_RD_STAT = 4'h3,
    SFCD_CMD_RD_FLAG = 4'h4,
    SFCD_CMD_RD_LOCK = 4'h5,
    SFCD_CMD_RD_NVC = 4'h6,
    SFCD_CMD_RD_VC = 4'h7,
    SFCD_CMD_RD_EVC = 4'h8,
    SFCD_CMD_WR_REG = 4'h9,
    SFCD_CMD_PROG = 4'ha,
    SFCD_CMD_ERASE = 4'hb,
    SFCD_CMD_WREN = 4'hc,
    SFCD_CMD_WRDI = 4'hd,
    SFCD_CMD_CLFLAG = 4'he,
    SFCD_CMD_SUSP = 4'hf
  } sfcd_cmd_e;

  typedef struct packed {
    logic valid;
    sfcd_cmd_e cmd;
    logic [1:0] addr_bytes;
    logic dummy;
    logic [8:0] max_bytes;
    logic needs_wel;
    logic [7:0] opcode;
  } sfcd_dec_s;
endpackage

//--- sim/sfcd_decoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sfcd_decoder_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic [3:0] lane_oe,
  input wire logic busy,
  input wire logic [7:0] flag_err_set,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_valid,
  input wire logic [7:0] evc_q,
  input wire logic wel_q,
  input wire logic [7:0] flag_q,
  input wire sfcd_pkg::sfcd_proto_e proto
);
  import sfcd_pkg::*;
  // ----
  // core domain checks
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_deselect; chip_select_n [*2]; endsequence
  sequence s_busy_held; busy [*2]; endsequence
  sequence s_idle_held; !busy [*2]; endsequence
  a_oe_idle: assert property (s_deselect |-> lane_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_proto_quad: assert property (evc_q[7:6] == 2'b00 |-> proto == SFCD_PROTO_QUAD)
    else $error("quad not selected");
  a_proto_dual: assert property (evc_q[7:6] == 2'b10 |-> proto == SFCD_PROTO_DUAL)
    else $error("dual not selected");
  a_proto_ext: assert property (evc_q[7:6] == 2'b11 |-> proto == SFCD_PROTO_EXT)
    else $error("extended not kept");
  a_valid_frame: assert property (cmd_valid |-> chip_select_n ##1 !cmd_valid)
    else $error("command event inside a frame");
  a_wel_cause: assert property ($rose(wel_q) |-> cmd_opcode == 8'h06 || $past(cmd_opcode) == 8'h06)
    else $error("write latch set by other opcode");
  a_evc_guard: assert property ($changed(evc_q) |-> $past(wel_q) || $past(wel_q, 2))
    else $error("config written without latch");
  a_err_sticky: assert property (($past(flag_q) & ~flag_q & 8'h3a) != 8'h00 |-> cmd_opcode == 8'h50 || $past(cmd_opcode) == 8'h50)
    else $error("error bit dropped without clear");
  a_err_set: assert property (flag_err_set[4] |-> ##[1:2] flag_q[4])
    else $error("error bit not set");
  a_ready_busy: assert property (s_busy_held |-> !flag_q[7])
    else $error("ready shown while busy");
  a_ready_idle: assert property (s_idle_held |-> flag_q[7])
    else $error("busy shown while idle");
endmodule
`default_nettype wire

//--- sim/sfcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfcd_host_model (
  output logic link_clk,
  output logic chip_select_n,
  output logic serial_lane_zero,
  output logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe,
  output logic oe_seen
);
  // ----
  // host side of the link
  // ----
  initial begin
    link_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_lane_zero = 1'b0;
    lane_in = 4'h0;
    oe_seen = 1'b0;
  end
  // clock stands low between frames; released lanes toggle so stale bits never pass as data
  task automatic xfer(input int w, input logic [39:0] tx, input int ntx, input int nrx,
      output logic [23:0] rx);
    rx = '0;
    oe_seen = 1'b0;
    chip_select_n = 1'b0;
    #10;
    for (int i = 0; i < ntx * 8; i += w) begin
      for (int b = 0; b < w; b++) lane_in[w-1-b] = tx[39-i-b];
      serial_lane_zero = lane_in[0];
      #7.5 link_clk = 1'b1;
      oe_seen |= |lane_oe;
      #7.5 link_clk = 1'b0;
    end
    for (int i = 0; i < nrx * 8; i += w) begin
      lane_in = ~lane_in;
      serial_lane_zero = ~serial_lane_zero;
      #7.5;
      for (int b = 0; b < w; b++) rx[23-i-b] = (w == 1) ? lane_out[1] : lane_out[w-1-b];
      oe_seen |= |lane_oe;
      link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
    end
    #7.5 chip_select_n = 1'b1;
    lane_in = ~lane_in;
    serial_lane_zero = ~serial_lane_zero;
  endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfcd_pkg::*;
  typedef struct packed {logic [39:0] tx; logic [3:0] ntx; logic [23:0] exp;} sfcd_row_s;
  logic core_clk, rst, link_clk, chip_select_n, serial_lane_zero, busy, oe_seen;
  logic cmd_valid, cmd_wel_ok, wel_q;
  logic [3:0] lane_in, lane_out, lane_oe;
  logic [7:0] status_in, vc_in, lock_in, flag_err_set, cmd_opcode, evc_q, flag_q;
  logic [15:0] nvc_in;
  logic [23:0] rx;
  sfcd_proto_e proto;
  int err_count = 0, n_compared = 0, n_cmd = 0, n_wok = 0, cycles = 0;
  // ----
  // register reads in extended protocol, three bytes each
  // ----
  sfcd_row_s rows [6] = '{'{40'h0500000000, 1, 24'ha4a4a4}, '{40'h7000000000, 1, 24'h808080},
    '{40'h8500000000, 1, 24'h5c5c5c}, '{40'h6500000000, 1, 24'hdfdfdf},
    '{40'he800000000, 4, 24'h030303}, '{40'hb500000000, 1, 24'h963c00}};
  sfcd_decoder u_sfcd_decoder (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .chip_select_n(chip_select_n), .serial_lane_zero(serial_lane_zero), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe), .status_in(status_in), .nvc_in(nvc_in),
    .vc_in(vc_in), .lock_in(lock_in), .busy(busy), .flag_err_set(flag_err_set),
    .dummy_cfg(4'h0), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
    .cmd_wel_ok(cmd_wel_ok), .evc_q(evc_q), .wel_q(wel_q), .flag_q(flag_q), .proto(proto));
  sfcd_host_model u_sfcd_host_model (.link_clk(link_clk), .chip_select_n(chip_select_n),
    .serial_lane_zero(serial_lane_zero), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe(lane_oe), .oe_seen(oe_seen));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (cmd_wel_ok === 1'b1) n_wok <= n_wok + 1;
    if (cycles == 30000) begin
      err_count++;
      summarize();
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every frame leaves room for the event to cross before the next one
  task automatic run(input int w, input logic [39:0] tx, input int ntx, input int nrx);
    u_sfcd_host_model.xfer(w, tx, ntx, nrx, rx);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    int c;
    rst = 1'b1;
    busy = 1'b0;
    flag_err_set = 8'h00;
    status_in = 8'ha4;
    vc_in = 8'h5c;
    lock_in = 8'h03;
    nvc_in = 16'h3c96;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      run(1, rows[i].tx, rows[i].ntx, 3);
      check(rx, rows[i].exp);
    end
    c = n_cmd;
    run(1, 40'haf00000000, 1, 1);
    check(24'(n_cmd - c), 24'h0);
    check(24'(oe_seen), 24'h0);
    busy <= 1'b1;
    run(1, 40'h0500000000, 1, 3);
    check(rx, 24'ha5a5a5);
    run(1, 40'h7000000000, 1, 3);
    check(rx, 24'h000000);
    busy <= 1'b0;
    flag_err_set <= 8'h10;
    @(posedge core_clk);
    flag_err_set <= 8'h00;
    run(1, 40'h7000000000, 1, 3);
    check(rx, 24'h909090);
    run(1, 40'h5000000000, 1, 0);
    run(1, 40'h7000000000, 1, 3);
    check(rx, 24'h808080);
    run(1, 40'h0600000000, 1, 0);
    check(24'(wel_q), 24'h1);
    run(1, 40'h0400000000, 1, 0);
    check(24'(wel_q), 24'h0);
    run(1, 40'h61bf000000, 2, 0);
    check(24'(evc_q), 24'hdf);
    run(1, 40'h0600000000, 1, 0);
    run(1, 40'h61bf000000, 2, 0);
    check(24'(proto), 24'(SFCD_PROTO_DUAL));
    check(24'(n_wok), 24'h2);
    run(2, 40'h0500000000, 1, 3);
    check(rx, 24'ha4a4a4);
    c = n_cmd;
    run(2, 40'h0300000000, 4, 1);
    check(24'(n_cmd - c), 24'h0);
    check(24'(oe_seen), 24'h0);
    run(2, 40'h0b00000000, 5, 2);
    check(24'(n_cmd - c), 24'h1);
    run(2, 40'h0600000000, 1, 0);
    run(2, 40'h611f000000, 2, 0);
    check(24'(proto), 24'(SFCD_PROTO_QUAD));
    run(4, 40'h6500000000, 1, 3);
    check(rx, 24'h1f1f1f);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({evc_q, flag_q, 7'h0, wel_q}, 24'hdf8000);
    check(24'(proto), 24'(SFCD_PROTO_EXT));
    summarize();
  end
endmodule
bind sfcd_decoder sfcd_decoder_assertions u_sfcd_decoder_assertions (.core_clk(core_clk),
  .rst(rst), .chip_select_n(chip_select_n), .lane_oe(lane_oe), .busy(busy),
  .flag_err_set(flag_err_set), .cmd_opcode(cmd_opcode), .cmd_valid(cmd_valid),
  .evc_q(evc_q), .wel_q(wel_q), .flag_q(flag_q), .proto(proto));
`default_nettype wire
